// file: hw/wave_consts.svh
`ifndef WAVE_CONSTS_SVH
`define WAVE_CONSTS_SVH

// ************************************************
// register byte offsets
// ************************************************
`define OFF_CTRL0     6'h00
`define OFF_CTRL1     6'h04
`define OFF_SD_CTRL   6'h08
`define OFF_SD_SRC    6'h0C
`define OFF_COUNT0    6'h10
`define NUM_COUNTS    6

// ************************************************
// field positions
// ************************************************
`define C0_EN         7
`define C0_LD         6
`define C0_CS_HI      4
`define C0_CS_LO      3
`define C0_MD_HI      2
`define C0_MD_LO      0
`define C1_RDBS       7
`define C1_FDBS       6
`define SD_ASE        7
`define SD_ARSEN      6
`define SD_AC_HI      3
`define SD_AC_LO      2
`define SD_BD_HI      1
`define SD_BD_LO      0
`define SRC_PIN       0

// ************************************************
// reset values and masks
// ************************************************
`define CTRL0_RST     8'h00
`define CTRL1_RST     8'h00
`define SD_CTRL_RST   8'h00
`define SD_SRC_RST    8'h00
`define COUNT_RST     8'h00
`define CTRL0_MASK    8'hDF
`define CTRL1_MASK    8'hCF
`define SD_CTRL_MASK  8'hCF
`define SD_SRC_MASK   8'h01

// ************************************************
// field codes
// ************************************************
`define CS_SYS4       2'h0
`define CS_SYS        2'h1
`define CS_HFOSC      2'h2
`define MD_STEER      3'h0
`define MD_SSTEER     3'h1
`define MD_FWD_FB     3'h2
`define MD_REV_FB     3'h3
`define MD_HALF       3'h4
`define MD_PUSHPULL   3'h5
`define OVR_INACTIVE  2'h0
`define OVR_TRISTATE  2'h1
`define OVR_LOW       2'h2
`define OVR_HIGH      2'h3
`define DIV4_LAST     2'h3

`endif

// file: hw/wave_pkg.sv
package wave_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {ST_OFF, ST_HELD, ST_RUN} run_state_e;
endpackage

// file: hw/unit_tick_gen.sv
`timescale 1ns/1ps
`include "wave_consts.svh"
module unit_tick_gen
    import wave_pkg::*;
(
    input  wire logic       clock_in,   // system clock
    input  wire logic       rst_in,     // sync reset
    input  wire logic       osc_in,     // internal oscillator pin
    input  wire logic [1:0] sel_in,     // clock source field
    output logic            tick_out    // one unit clock tick
);
    logic [1:0] div_reg;
    logic       osc_meta_reg;
    logic       osc_sync_reg;
    logic       osc_last_reg;

    // divide-by-four counter
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end

    // oscillator synchroniser and edge history
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_last_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_in;
            osc_sync_reg <= osc_meta_reg;
            osc_last_reg <= osc_sync_reg;
        end
    end

    // source select, reserved code gives no ticks
    always_comb begin
        case (sel_in)
            `CS_SYS:   tick_out = 1'b1;
            `CS_SYS4:  tick_out = (div_reg == `DIV4_LAST);
            `CS_HFOSC: tick_out = osc_sync_reg & ~osc_last_reg;
            default:   tick_out = 1'b0;
        endcase
    end
endmodule

// file: hw/deadband_timer.sv
`timescale 1ns/1ps
module deadband_timer
    import wave_pkg::*;
(
    input  wire logic  clock_in,   // system clock
    input  wire logic  rst_in,     // sync reset
    input  wire logic  level_in,   // undelayed level
    input  wire byte_t count_in,   // dead-band count
    input  wire logic  chain_in,   // count system clocks
    input  wire logic  tick_in,    // unit clock tick
    output logic       level_out   // rise-delayed level
);
    byte_t cnt_reg;

    // rise waits count steps, fall is immediate
    always_ff @(posedge clock_in) begin
        if (rst_in || !level_in) begin
            cnt_reg   <= 8'h00;
            level_out <= 1'b0;
        end else if (!level_out) begin
            if (cnt_reg >= count_in) begin
                level_out <= 1'b1;
            end else if (chain_in || tick_in) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
endmodule

// file: hw/waveform_unit.sv
`timescale 1ns/1ps
`include "wave_consts.svh"
module waveform_unit
    import wave_pkg::*;
(
    input  wire logic        clock_in,             // system clock, 10 MHz
    input  wire logic        rst_in,               // sync reset, active high
    input  wire logic [5:0]  address_in,           // avalon byte address
    input  wire logic        read_in,              // avalon read
    input  wire logic        write_in,             // avalon write
    input  wire logic [31:0] writedata_in,         // avalon write data
    input  wire logic [3:0]  byteenable_in,        // avalon byte enables
    output logic [31:0]      readdata_out,         // avalon read data
    output logic             waitrequest_out,      // avalon wait
    input  wire logic        osc_in,               // internal oscillator
    input  wire logic        rise_event_in,        // selected rising source
    input  wire logic        fall_event_in,        // selected falling source
    input  wire logic        shutdown_n_in,        // shutdown source, low
    output logic             drive_out_first_out,  // output A level
    output logic             drive_out_second_out, // output B level
    output logic             drive_out_third_out,  // output C level
    output logic             drive_out_fourth_out, // output D level
    output logic             drive_en_first_out,   // output A enable
    output logic             drive_en_second_out,  // output B enable
    output logic             drive_en_third_out,   // output C enable
    output logic             drive_en_fourth_out   // output D enable
);
    // ************************************************
    // declarations
    // ************************************************
    byte_t      unit_control_zero_reg;
    byte_t      unit_control_one_reg;
    byte_t      shutdown_control_reg;
    byte_t      shutdown_source_reg;
    byte_t      count_reg [`NUM_COUNTS];
    byte_t      work_reg  [`NUM_COUNTS];
    logic       ack_reg;
    logic       take_wr;
    logic [2:0] rise_sync_reg;
    logic [2:0] fall_sync_reg;
    logic [1:0] sd_sync_reg;
    logic       rise_edge;
    logic       fall_edge;
    logic       fault;
    logic       pwm_reg;
    logic       alt_reg;
    logic       unit_tick;
    logic       rise_del;
    logic       fall_del;
    logic [3:0] act_vec;
    logic [3:0] pol_vec;
    logic [3:0] drv_next;
    logic [3:0] en_next;
    logic [3:0] drv_reg;
    logic [3:0] en_reg;
    logic       en_bit;
    logic       ld_bit;
    logic       ase_bit;
    logic [2:0] mode;
    logic [1:0] csel;
    run_state_e state_reg;

    // true when the address names a count register
    function automatic logic is_count(input logic [5:0] a);
        return (a >= `OFF_COUNT0) && (a < `OFF_COUNT0 + 6'(4 * `NUM_COUNTS));
    endfunction

    // count register index from address
    function automatic logic [2:0] count_idx(input logic [5:0] a);
        logic [5:0] d;
        d = a - `OFF_COUNT0;
        return d[4:2];
    endfunction

    assign en_bit  = unit_control_zero_reg[`C0_EN];
    assign ld_bit  = unit_control_zero_reg[`C0_LD];
    assign csel    = unit_control_zero_reg[`C0_CS_HI:`C0_CS_LO];
    assign mode    = unit_control_zero_reg[`C0_MD_HI:`C0_MD_LO];
    assign ase_bit = shutdown_control_reg[`SD_ASE];
    assign pol_vec = unit_control_one_reg[3:0];

    // ************************************************
    // avalon slave
    // ************************************************
    // one wait state per access
    assign waitrequest_out = (read_in | write_in) & ~ack_reg;
    assign take_wr         = write_in & ack_reg & byteenable_in[0];

    // acknowledge toggles on the second cycle
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read_in | write_in) & ~ack_reg;
        end
    end

    // read data captured in the wait cycle, unmapped reads zero
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            readdata_out <= 32'h0000_0000;
        end else if (read_in && !ack_reg) begin
            readdata_out <= 32'h0000_0000;
            if (address_in == `OFF_CTRL0) begin
                readdata_out[7:0] <= unit_control_zero_reg;
            end else if (address_in == `OFF_CTRL1) begin
                readdata_out[7:0] <= unit_control_one_reg;
            end else if (address_in == `OFF_SD_CTRL) begin
                readdata_out[7:0] <= shutdown_control_reg;
            end else if (address_in == `OFF_SD_SRC) begin
                readdata_out[7:0] <= shutdown_source_reg;
            end else if (is_count(address_in)) begin
                readdata_out[7:0] <= count_reg[count_idx(address_in)];
            end
        end
    end

    // ************************************************
    // control registers
    // ************************************************
    // control 0: software writes, hardware clears load bit
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            unit_control_zero_reg <= `CTRL0_RST;
        end else if (take_wr && address_in == `OFF_CTRL0) begin
            unit_control_zero_reg <= writedata_in[7:0] & `CTRL0_MASK;
        end else if (en_bit && ld_bit && rise_edge) begin
            unit_control_zero_reg[`C0_LD] <= 1'b0;
        end
    end

    // control 1 and shutdown source
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            unit_control_one_reg <= `CTRL1_RST;
            shutdown_source_reg  <= `SD_SRC_RST;
        end else if (take_wr && address_in == `OFF_CTRL1) begin
            unit_control_one_reg <= writedata_in[7:0] & `CTRL1_MASK;
        end else if (take_wr && address_in == `OFF_SD_SRC) begin
            shutdown_source_reg <= writedata_in[7:0] & `SD_SRC_MASK;
        end
    end

    // shutdown control, a held fault wins over any clear
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            shutdown_control_reg <= `SD_CTRL_RST;
        end else begin
            if (take_wr && address_in == `OFF_SD_CTRL) begin
                shutdown_control_reg <= writedata_in[7:0] & `SD_CTRL_MASK;
            end else if (shutdown_control_reg[`SD_ARSEN] && !fault) begin
                shutdown_control_reg[`SD_ASE] <= 1'b0;
            end
            if (fault) begin
                shutdown_control_reg[`SD_ASE] <= 1'b1;
            end
        end
    end

    // count registers and their working buffers
    generate
        for (genvar i = 0; i < `NUM_COUNTS; i++) begin : g_count
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    count_reg[i] <= `COUNT_RST;
                    work_reg[i]  <= `COUNT_RST;
                end else begin
                    if (take_wr && is_count(address_in) && count_idx(address_in) == 3'(i)) begin
                        count_reg[i] <= writedata_in[7:0];
                        if (!en_bit) begin
                            work_reg[i] <= writedata_in[7:0];
                        end
                    end
                    if (en_bit && ld_bit && rise_edge) begin
                        work_reg[i] <= count_reg[i];
                    end
                end
            end
        end
    endgenerate

    // ************************************************
    // input synchronisers
    // ************************************************
    // two flops before any logic, third for edges
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rise_sync_reg <= 3'h0;
            fall_sync_reg <= 3'h0;
            sd_sync_reg   <= 2'h3;
        end else begin
            rise_sync_reg <= {rise_sync_reg[1:0], rise_event_in};
            fall_sync_reg <= {fall_sync_reg[1:0], fall_event_in};
            sd_sync_reg   <= {sd_sync_reg[0], shutdown_n_in};
        end
    end

    assign rise_edge = rise_sync_reg[1] & ~rise_sync_reg[2];
    assign fall_edge = fall_sync_reg[1] & ~fall_sync_reg[2];
    assign fault     = shutdown_source_reg[`SRC_PIN] & ~sd_sync_reg[1];

    // ************************************************
    // waveform core
    // ************************************************
    unit_tick_gen u_tick (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .osc_in   (osc_in),
        .sel_in   (csel),
        .tick_out (unit_tick)
    );

    // primary level, set by rising and cleared by falling events
    always_ff @(posedge clock_in) begin
        if (rst_in || !en_bit) begin
            pwm_reg <= 1'b0;
            alt_reg <= 1'b0;
        end else if (rise_edge) begin
            pwm_reg <= 1'b1;
            alt_reg <= ~alt_reg;
        end else if (fall_edge) begin
            pwm_reg <= 1'b0;
        end
    end

    deadband_timer u_rise_db (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .level_in  (pwm_reg),
        .count_in  (work_reg[0]),
        .chain_in  (unit_control_one_reg[`C1_RDBS]),
        .tick_in   (unit_tick),
        .level_out (rise_del)
    );

    deadband_timer u_fall_db (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .level_in  (~pwm_reg),
        .count_in  (work_reg[1]),
        .chain_in  (unit_control_one_reg[`C1_FDBS]),
        .tick_in   (unit_tick),
        .level_out (fall_del)
    );

    // active levels per mode, bit 0 is output A
    always_comb begin
        act_vec = 4'h0;
        case (mode)
            `MD_STEER:    act_vec = {4{rise_del}};
            `MD_SSTEER:   act_vec = {4{rise_del}};
            `MD_FWD_FB:   act_vec = {rise_del, 1'b0, 1'b0, 1'b1};
            `MD_REV_FB:   act_vec = {1'b0, 1'b1, rise_del, 1'b0};
            `MD_HALF:     act_vec = {fall_del, rise_del, fall_del, rise_del};
            `MD_PUSHPULL: act_vec = {2'h0, rise_del & ~alt_reg, rise_del & alt_reg};
            default:      act_vec = 4'h0;
        endcase
        if (csel == 2'h3) begin
            act_vec = 4'h0;
        end
    end

    // run state: enabled units start held in shutdown
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg <= ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    if (en_bit) begin
                        state_reg <= ST_HELD;
                    end
                end
                ST_HELD: begin
                    if (!en_bit) begin
                        state_reg <= ST_OFF;
                    end else if (!ase_bit && rise_edge) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!en_bit) begin
                        state_reg <= ST_OFF;
                    end else if (ase_bit) begin
                        state_reg <= ST_HELD;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // output levels: waveform, override or off
    always_comb begin
        drv_next = act_vec ^ pol_vec;
        en_next  = 4'hF;
        if (state_reg == ST_OFF) begin
            drv_next = 4'h0;
            en_next  = 4'h0;
        end else if (state_reg == ST_HELD || ase_bit) begin
            for (int k = 0; k < 4; k++) begin
                case (k[0] ? shutdown_control_reg[`SD_BD_HI:`SD_BD_LO]
                           : shutdown_control_reg[`SD_AC_HI:`SD_AC_LO])
                    `OVR_TRISTATE: begin
                        drv_next[k] = 1'b0;
                        en_next[k]  = 1'b0;
                    end
                    `OVR_LOW:  drv_next[k] = 1'b0;
                    `OVR_HIGH: drv_next[k] = 1'b1;
                    default:   drv_next[k] = pol_vec[k];
                endcase
            end
        end
    end

    // registered pin drive
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            drv_reg <= 4'h0;
            en_reg  <= 4'h0;
        end else begin
            drv_reg <= drv_next;
            en_reg  <= en_next;
        end
    end

    assign drive_out_first_out  = drv_reg[0];
    assign drive_out_second_out = drv_reg[1];
    assign drive_out_third_out  = drv_reg[2];
    assign drive_out_fourth_out = drv_reg[3];
    assign drive_en_first_out   = en_reg[0];
    assign drive_en_second_out  = en_reg[1];
    assign drive_en_third_out   = en_reg[2];
    assign drive_en_fourth_out  = en_reg[3];

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_held_ready;
        state_reg == ST_HELD && en_bit && !ase_bit;
    endsequence

    sequence s_first_rise;
        rise_edge;
    endsequence

    property p_off_when_disabled;
        !en_bit |=> state_reg == ST_OFF ##1 !drive_en_first_out;
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled)
        else $error("unit not off after enable cleared");

    property p_load_transfer;
        en_bit && ld_bit && rise_edge && !take_wr |=> work_reg[0] == $past(count_reg[0]) && !ld_bit;
    endproperty
    a_load_transfer: assert property (p_load_transfer)
        else $error("load request did not transfer counts");

    property p_load_held;
        en_bit && ld_bit && !rise_edge && !take_wr |=> ld_bit;
    endproperty
    a_load_held: assert property (p_load_held)
        else $error("load bit cleared without transfer");

    property p_direct_write;
        take_wr && address_in == `OFF_COUNT0 && !en_bit |=> work_reg[0] == $past(writedata_in[7:0]);
    endproperty
    a_direct_write: assert property (p_direct_write)
        else $error("disabled write missed working buffer");

    property p_reserved_clock;
        csel == 2'h3 |-> !unit_tick && act_vec == 4'h0;
    endproperty
    a_reserved_clock: assert property (p_reserved_clock)
        else $error("reserved clock source produced activity");

    property p_reserved_mode;
        mode[2:1] == 2'h3 && state_reg == ST_RUN |=> drv_reg == $past(pol_vec);
    endproperty
    a_reserved_mode: assert property (p_reserved_mode)
        else $error("reserved mode drove an active level");

    property p_polarity;
        state_reg == ST_RUN && !ase_bit |=> drive_out_first_out == $past(act_vec[0] ^ pol_vec[0]);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("output A polarity wrong");

    property p_shutdown_holds;
        en_bit && ase_bit |=> state_reg != ST_RUN;
    endproperty
    a_shutdown_holds: assert property (p_shutdown_holds)
        else $error("shutdown did not stop waveforms");

    property p_first_rise;
        s_held_ready ##0 s_first_rise |=> state_reg == ST_RUN;
    endproperty
    a_first_rise: assert property (p_first_rise)
        else $error("no start on first rising event");

    property p_no_early_start;
        state_reg == ST_HELD && !rise_edge |=> state_reg != ST_RUN;
    endproperty
    a_no_early_start: assert property (p_no_early_start)
        else $error("started without rising event");

    property p_auto_restart;
        ase_bit && shutdown_control_reg[`SD_ARSEN] && !fault && !take_wr ##1 !fault |-> !ase_bit;
    endproperty
    a_auto_restart: assert property (p_auto_restart)
        else $error("auto-restart did not clear shutdown");

    property p_reserved_read;
        read_in && !ack_reg && address_in == `OFF_CTRL1 |=> readdata_out[5:4] == 2'h0 && readdata_out[31:8] == 24'h0;
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("unimplemented bits read nonzero");
endmodule

// file: bench/power_stage.sv
`timescale 1ns/1ps
// ************************************************
// power stage switch inputs
// ************************************************
module power_stage (
    input  wire logic [3:0] level_in, // gate levels
    input  wire logic [3:0] en_in,    // gate enables
    output logic      [3:0] pin_out   // switch inputs
);
    // a released gate falls to its pull-down
    assign pin_out = level_in & en_in;
endmodule

// file: bench/test_waveform_unit.sv
`timescale 1ns/1ps
`include "wave_consts.svh"
module test_waveform_unit
    import wave_pkg::*;
;
    logic        clock_in = 1'b0, rst_in = 1'b1, read_in = 1'b0, write_in = 1'b0;
    logic        rise_event_in = 1'b0, fall_event_in = 1'b0, shutdown_n_in = 1'b1;
    logic [5:0]  address_in = 6'h00;
    logic [31:0] writedata_in = 32'h00000000;
    logic [31:0] readdata_out;
    logic        waitrequest_out;
    logic [3:0]  lv, en, pins;
    logic        osc_in = 1'b0;
    int          failures = 0, check_count = 0;
    byte_t       q;

    // ************************************************
    // clock, design and switches
    // ************************************************
    always #50 clock_in = ~clock_in;
    // free-running oscillator pin, one rising edge every two clocks
    always @(posedge clock_in) osc_in <= ~osc_in;
    waveform_unit uut (.clock_in, .rst_in, .address_in, .read_in, .write_in, .writedata_in,
        .byteenable_in(4'hF), .readdata_out, .waitrequest_out, .osc_in, .rise_event_in,
        .fall_event_in, .shutdown_n_in, .drive_out_first_out(lv[0]), .drive_out_second_out(lv[1]),
        .drive_out_third_out(lv[2]), .drive_out_fourth_out(lv[3]), .drive_en_first_out(en[0]),
        .drive_en_second_out(en[1]), .drive_en_third_out(en[2]), .drive_en_fourth_out(en[3]));
    power_stage stage (.level_in(lv), .en_in(en), .pin_out(pins));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input byte_t d);
        int n;
        n = 0;
        address_in <= a;
        write_in <= wr;
        read_in <= !wr;
        writedata_in <= {24'h000000, d};
        @(posedge clock_in);
        while (waitrequest_out !== 1'b0) begin
            n++;
            if (n > 50) begin
                failures++;
                stop_test();
            end
            @(posedge clock_in);
        end
        q = readdata_out[7:0];
        read_in <= 1'b0;
        write_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic wr(input logic [5:0] a, input byte_t d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string s, input logic [5:0] a, input byte_t e);
        bus(1'b0, a, 8'h00);
        chk(s, q, e);
    endtask
    // one event pulse, then time for sync and dead band
    task automatic ev(input logic r);
        if (r) rise_event_in <= 1'b1;
        else fall_event_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rise_event_in <= 1'b0;
        fall_event_in <= 1'b0;
        repeat (12) @(posedge clock_in);
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_regs;
        rdc("ctrl0", `OFF_CTRL0, 8'h00);
        wr(`OFF_CTRL1, 8'hFF);
        rdc("ctrl1", `OFF_CTRL1, 8'hCF);
        wr(`OFF_CTRL0, 8'h27);
        rdc("ctrl0", `OFF_CTRL0, 8'h07);
        for (int i = 0; i < 6; i++) begin
            wr(`OFF_CTRL0, {3'h0, 2'(i % 3), 3'(i)});
            rdc("mode", `OFF_CTRL0, {3'h0, 2'(i % 3), 3'(i)});
        end
        rdc("unmapped", 6'h3C, 8'h00);
    endtask
    task automatic t_start;
        wr(`OFF_CTRL0, 8'h0C);
        wr(`OFF_COUNT0, 8'h02);
        wr(`OFF_SD_CTRL, 8'h8E);
        wr(`OFF_CTRL1, 8'h0F);
        wr(`OFF_CTRL0, 8'h8C);
        // state enters held one edge after enable, pins follow one edge later
        repeat (2) @(posedge clock_in);
        chk("override", {4'h0, pins}, 8'h05);
        wr(`OFF_SD_CTRL, 8'h85);
        @(posedge clock_in);
        chk("enables", {4'h0, en}, 8'h00);
        wr(`OFF_SD_CTRL, 8'h0E);
        @(posedge clock_in);
        chk("held", {4'h0, pins}, 8'h05);
        ev(1'b1);
        chk("rise", {6'h00, pins[1:0]}, 8'h02);
        ev(1'b0);
        chk("fall", {6'h00, pins[1:0]}, 8'h01);
    endtask
    task automatic t_load;
        wr(`OFF_COUNT0, 8'h04);
        wr(`OFF_CTRL0, 8'hCC);
        rdc("load set", `OFF_CTRL0, 8'hCC);
        ev(1'b1);
        rdc("load done", `OFF_CTRL0, 8'h8C);
        ev(1'b0);
    endtask
    task automatic t_rsv;
        wr(`OFF_CTRL1, 8'h00);
        wr(`OFF_CTRL0, 8'h8E);
        ev(1'b1);
        chk("reserved", {4'h0, pins}, 8'h00);
        wr(`OFF_CTRL0, 8'h9C);
        ev(1'b0);
        chk("reserved clock", {4'h0, pins}, 8'h00);
        // oscillator ticks every second clock: dead band of 4 ends later than on sysclk
        wr(`OFF_CTRL0, 8'h94);
        rise_event_in <= 1'b1;
        repeat (10) @(posedge clock_in);
        chk("osc early", {6'h00, pins[1:0]}, 8'h00);
        repeat (6) @(posedge clock_in);
        chk("osc late", {6'h00, pins[1:0]}, 8'h01);
        rise_event_in <= 1'b0;
        ev(1'b0);
        wr(`OFF_CTRL0, 8'h8C);
    endtask
    task automatic t_auto;
        wr(`OFF_SD_SRC, 8'h01);
        wr(`OFF_SD_CTRL, 8'h4E);
        shutdown_n_in <= 1'b0;
        repeat (6) @(posedge clock_in);
        rdc("fault", `OFF_SD_CTRL, 8'hCE);
        chk("fault pins", {4'h0, pins}, 8'h05);
        shutdown_n_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        rdc("restart", `OFF_SD_CTRL, 8'h4E);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        t_regs();
        t_start();
        t_load();
        t_rsv();
        t_auto();
        stop_test();
    end
endmodule
